/* dv/bcs_mem.sv */
// Purpose: memory and i/o model behind the bus pins
// Assumes: read data is the address low half xor 5a5a
// Notes: slow mode stalls ready at random
`timescale 1ns/1ps
module bcs_mem
  import bcs_pkg::*;
(
  input wire logic pclk,
  input wire logic slow,
  input wire bcs_pkg::bcs_pins_t pins,
  output logic srdy,
  output logic ardy,
  output logic [15:0] ad_i
);
  initial begin
    srdy = 1'b0;
    ardy = 1'b0;
    ad_i = 16'h0000;
  end
  always @(posedge pclk) begin
    srdy <= !slow || ($urandom_range(3) == 0);
    ardy <= slow && ($urandom_range(2) == 0);
    if (!pins.rd_n && pins.rd_oe) begin
      ad_i <= pins.addr[15:0] ^ 16'h5a5a;
    end else begin
      ad_i <= ~ad_i; // released bus never keeps the old word
    end
  end
endmodule // bcs_mem

/* dv/bcs_top_sva.sv */
// Purpose: pin protocol checker for bcs_top
// Assumes: sees only the top ports; one clock domain
// Notes: a ready-age counter bounds the t3 wait
`timescale 1ns/1ps
module bcs_top_sva
  import bcs_pkg::*;
#(
  parameter int TICK_DIV = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic srdy,
  input wire logic ardy,
  input wire logic hold_req,
  input wire logic once_mode,
  input wire logic half_clock_strap_n,
  input wire logic second_refresh_i,
  input wire logic [15:0] ad_i,
  input wire bcs_pkg::bcs_pins_t pins
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------
  // helper
  // ------
  // saturating age of the last ready level, so a stuck t3 exit is caught
  logic [3:0] age_ff;
  logic [3:0] nxt_age;
  always_comb nxt_age = (srdy || ardy) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_ff <= 4'hf;
    end else begin
      age_ff <= nxt_age;
    end
  end
  // ------
  // properties
  // ------
  sequence s_lock_t1; $fell(pins.lock_n); endsequence
  sequence s_rd_on; $fell(pins.rd_n) && pins.rd_oe; endsequence
  property p_lock_t1; s_lock_t1 |-> ##[1:4] pins.lock_n; endproperty
  property p_sel6_hold; pins.hold_ack |-> pins.sel6_n; endproperty
  property p_rd_hold; pins.hold_ack |-> !pins.rd_oe; endproperty
  property p_ct_hold; pins.hold_ack |-> !pins.ctype_oe && !pins.dma_oe; endproperty
  property p_rd_float; s_rd_on |-> !$past(pins.ad_oe) && !pins.ad_oe; endproperty
  property p_rd_dir; !pins.rd_n && pins.rd_oe |-> !pins.ctype_n[1]; endproperty
  property p_rdy; $rose(pins.rd_n) && pins.rd_oe |-> age_ff < 4'h8; endproperty
  property p_sel6_ad; $fell(pins.sel6_n) |-> pins.ad_oe; endproperty
  property p_a2_hold; pins.hold_ack && $past(pins.hold_ack) |-> $stable(pins.a2); endproperty
  property p_dma_t2; $rose(pins.dma_flag) |-> $past(pins.ctype_n) != 3'h7; endproperty
  a_lock_t1: assert property (p_lock_t1) else $error("lock past t1");
  a_sel6_hold: assert property (p_sel6_hold) else $error("sel6 low in hold");
  a_rd_hold: assert property (p_rd_hold) else $error("rd driven in hold");
  a_ct_hold: assert property (p_ct_hold) else $error("status driven in hold");
  a_rd_float: assert property (p_rd_float) else $error("rd before float");
  a_rd_dir: assert property (p_rd_dir) else $error("rd on write code");
  a_rdy: assert property (p_rdy) else $error("t3 left without ready");
  a_sel6_ad: assert property (p_sel6_ad) else $error("sel6 without address");
  a_a2_hold: assert property (p_a2_hold) else $error("a2 moved in hold");
  a_dma_t2: assert property (p_dma_t2) else $error("dma flag in t1");
endmodule // bcs_top_sva

bind bcs_top bcs_top_sva #(.TICK_DIV(TICK_DIV)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .srdy(srdy), .ardy(ardy),
  .hold_req(hold_req), .once_mode(once_mode), .half_clock_strap_n(half_clock_strap_n),
  .second_refresh_i(second_refresh_i), .ad_i(ad_i), .pins(pins));

/* dv/bcs_top_tb.sv */
// Purpose: self-checking bench for bcs_top
// Assumes: bcs_mem answers every read
// Notes: cycled types, random addresses and waits from a fixed seed
`timescale 1ns/1ps
module bcs_top_tb;
  import bcs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic hold_req = 0, once_mode = 0, half_clock_strap_n = 1, second_refresh_i = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, srdy, ardy, e, clr = 0, sel, adr, r2, rm, dm;
  logic [2:0] ct;
  logic [15:0] ad_i;
  bcs_pins_t pins;
  int num_errors = 0, checks = 0;
  always #4 pclk = ~pclk;
  bcs_top #(.TICK_DIV(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .srdy(srdy), .ardy(ardy), .hold_req(hold_req),
    .once_mode(once_mode), .half_clock_strap_n(half_clock_strap_n),
    .second_refresh_i(second_refresh_i), .ad_i(ad_i), .pins(pins));
  bcs_mem u_mem (.pclk(pclk), .slow(slow), .pins(pins), .srdy(srdy), .ardy(ardy),
    .ad_i(ad_i));
  // ------
  // sticky pin monitors, cleared before each cycle
  // ------
  always @(posedge pclk) begin
    if (clr) begin
      {sel, adr, r2, rm, dm} <= 5'h00;
    end else begin
      sel <= sel | !pins.sel6_n;
      adr <= adr | (pins.ad_oe && pins.ctype_n != 3'h7);
      r2 <= r2 | (!pins.second_refresh_n && pins.rfsh2_oe);
      rm <= rm | !pins.rfsh_mid_n;
      dm <= dm | (pins.dma_flag && pins.dma_oe);
      if (pins.ctype_n != 3'h7) ct <= pins.ctype_n;
    end
  end
  function automatic logic [15:0] mdat(input logic [19:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) num_errors++;
  endtask
  task idle;
    int n;
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 100) begin
      apb(1'b0, 12'h014, 32'h0);
      n++;
    end
  endtask
  task cyc(input logic [2:0] t, input logic [19:0] a, input logic [4:0] f);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    apb(1'b1, 12'h00c, {4'h0, f, t, a});
    idle();
  endtask
  task do_reset(input logic aden, input logic half_n, input int k);
    int n;
    presetn <= 1'b0;
    second_refresh_i <= aden;
    half_clock_strap_n <= half_n;
    repeat (6) @(posedge pclk);
    chk({pins.sel6_n, pins.rd_oe, pins.ctype_oe, pins.dma_oe}, 4'b1000);
    presetn <= 1'b1;
    n = 0;
    while (pins.ctype_n !== 3'h4 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk(pins.addr, 20'hffff0);
    chk(n >= 13 * k && n <= 13 * k + 6, 1);
    idle();
    apb(1'b0, 12'h014, 32'h0);
    chk(r[3:2], {!half_n, aden});
  endtask
  initial begin
    int n;
    logic [19:0] a;
    logic [11:0] pg;
    logic [2:0] t;
    logic [4:0] f;
    void'($urandom(69171));
    do_reset(1'b0, 1'b1, 1);
    apb(1'b0, 12'h01c, 32'h0);
    chk(e, 1); // unmapped place
    apb(1'b1, 12'h004, 32'h80);
    for (int i = 0; i < 14; i++) begin
      t = 3'(i % 7);
      a = 20'($urandom);
      f = {3'h2, 2'($urandom)};
      slow <= 1'($urandom);
      cyc(t, a, f);
      chk(ct, t);
      chk(dm, f[0]);
      chk(pins.a2, a[2]);
      if (t == 3'h1 || t == 3'h4 || t == 3'h5) begin
        chk(adr, 1);
        apb(1'b0, 12'h010, 32'h0);
        chk(r[15:0], mdat(a));
      end
    end
    $display("test types done");
    pg = 12'($urandom);
    apb(1'b1, 12'h000, {14'h0, pg[9:0], 8'h00});
    pg = {pg[9:0], 2'b00} + 12'h006;
    cyc(3'h5, {pg, 8'($urandom)}, 5'h00);
    chk(sel, 1);
    cyc(3'h5, {pg + 12'h001, 8'h00}, 5'h00);
    chk(sel, 0);
    apb(1'b1, 12'h00c, {12'h005, a});
    apb(1'b1, 12'h00c, {12'h005, a});
    chk(e, 1); // command while busy
    idle();
    $display("test select done");
    hold_req <= 1'b1;
    n = 0;
    while (pins.hold_ack !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
    chk({pins.sel6_n, pins.rd_oe, pins.ctype_oe, pins.dma_oe, pins.a2}, {4'h8, a[2]});
    hold_req <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b1, 12'h018, 32'h1);
    cyc(3'h5, a, 5'h04);
    chk({r2, rm}, 2'b01);
    apb(1'b1, 12'h018, 32'h0);
    cyc(3'h5, a, 5'h04);
    chk(r2, 1);
    $display("test hold refresh done");
    do_reset(1'b1, 1'b0, 2);
    apb(1'b1, 12'h004, 32'h80);
    cyc(3'h5, a, 5'h08);
    chk(adr, 0);
    cyc(3'h5, a, 5'h10);
    chk(adr, 1);
    $display("test straps done");
    once_mode <= 1'b1;
    do_reset(1'b0, 1'b1, 1);
    chk(r[4], 1);
    chk({pins.rd_oe, pins.ctype_oe, pins.dma_oe, pins.a2_oe, pins.rfsh2_oe}, 5'h00);
    once_mode <= 1'b0;
    $display("test once done");
    end_sim;
  end
  initial begin
    #400000;
    num_errors++;
    end_sim;
  end
endmodule // bcs_top_tb

/* verilog/bcs_cfg.svh */
// Purpose: constants for the bus cycle status and strap block
// Assumes: included by the top module
// Notes: byte offsets on a 32-bit apb bus
`ifndef BCS_CFG_SVH
`define BCS_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define BCS_OFF_MPAUX 12'h000
`define BCS_OFF_LMSEL 12'h004
`define BCS_OFF_UMSEL 12'h008
`define BCS_OFF_CMD 12'h00c
`define BCS_OFF_DATA 12'h010
`define BCS_OFF_STAT 12'h014
`define BCS_OFF_MODE 12'h018
// ----------------------------------------
// fields
// ----------------------------------------
`define BCS_EX_BIT 7
`define BCS_DA_BIT 7
`define BCS_PBASE_HI 19
`define BCS_PBASE_LO 10
`define BCS_SEL6_IDX 3'h6
`define BCS_RGN_LOW 2'h1
`define BCS_RGN_UPPER 2'h2
`define BCS_RESET_ADDR 20'hffff0
// ----------------------------------------
// cycle type codes, active low on the pins
// ----------------------------------------
`define BCS_CT_INTA 3'h0
`define BCS_CT_IORD 3'h1
`define BCS_CT_IOWR 3'h2
`define BCS_CT_HALT 3'h3
`define BCS_CT_FETCH 3'h4
`define BCS_CT_MRD 3'h5
`define BCS_CT_MWR 3'h6
`define BCS_CT_PASSIVE 3'h7
// ----------------------------------------
// timing
// ----------------------------------------
`define BCS_TICK_DIV 2
`define BCS_START_HALF_PERIODS 13
`endif

/* verilog/bcs_pkg.sv */
// Purpose: types for the bus cycle status and strap block
// Assumes: bcs_cfg.svh holds the numbers
// Notes: none
package bcs_pkg;
  typedef enum logic [2:0] {
    ST_START, ST_IDLE, ST_T1, ST_T2, ST_T3, ST_T4, ST_HOLD
  } bcs_state_t;

  typedef struct packed {
    logic [1:0] region;
    logic rfsh;
    logic lock;
    logic dma;
    logic [2:0] ctype;
    logic [19:0] addr;
  } bcs_req_t;

  typedef struct packed {
    logic [15:0] ad_o;
    logic ad_oe;
    logic [19:0] addr;
    logic rd_n;
    logic rd_oe;
    logic [2:0] ctype_n;
    logic ctype_oe;
    logic dma_flag;
    logic dma_oe;
    logic lock_n;
    logic sel6_n;
    logic a2;
    logic a2_oe;
    logic second_refresh_n;
    logic rfsh2_oe;
    logic rfsh_mid_n;
    logic hold_ack;
  } bcs_pins_t;
endpackage

/* verilog/bcs_top.sv */
// Purpose: external bus control, cycle status, peripheral select six and straps
// Assumes: apb register access on pclk; bus runs on a tick enable from a divider
// Notes: one bus t-state per tick; writes to the command register start a cycle
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`include "bcs_cfg.svh"

module bcs_top #(
  parameter int TICK_DIV = `BCS_TICK_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic srdy,
  input wire logic ardy,
  input wire logic hold_req,
  input wire logic once_mode,
  input wire logic half_clock_strap_n,
  input wire logic second_refresh_i,
  input wire logic [15:0] ad_i,
  output bcs_pkg::bcs_pins_t pins
);
  import bcs_pkg::*;

  localparam int START_CYC = `BCS_START_HALF_PERIODS * TICK_DIV / 2;

  typedef struct packed {
    logic rs1;
    logic rs2;
    logic run;
    logic strap_done;
    logic aden;
    logic half;
    logic once;
    logic [15:0] cnt;
    logic [7:0] div;
    logic tick;
    bcs_state_t state;
    logic pending;
    bcs_req_t req;
    bcs_req_t cur;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [9:0] pbase;
    logic ex;
    logic lm_da;
    logic um_da;
    logic psram;
    logic sy1;
    logic sy2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    bcs_pins_t pins;
  } bcs_st_t;

  bcs_st_t st_ff;
  bcs_st_t nxt_st;
  logic ready;
  logic is_read;
  logic is_write;
  logic addr_off;
  logic hit6;
  logic [15:0] div_lim;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  always_comb begin
    ready = srdy | st_ff.sy2;
    is_read = st_ff.cur.ctype == `BCS_CT_IORD || st_ff.cur.ctype == `BCS_CT_MRD
      || st_ff.cur.ctype == `BCS_CT_FETCH;
    is_write = st_ff.cur.ctype == `BCS_CT_IOWR || st_ff.cur.ctype == `BCS_CT_MWR;
    // strap low ignores the disable bits entirely
    addr_off = st_ff.aden && ((st_ff.cur.region == `BCS_RGN_LOW && st_ff.lm_da)
      || (st_ff.cur.region == `BCS_RGN_UPPER && st_ff.um_da));
    // seventh 256-byte region above the programmed base
    hit6 = st_ff.cur.addr[`BCS_PBASE_HI:8] == {st_ff.pbase, 2'h0} + 12'(`BCS_SEL6_IDX);
    div_lim = st_ff.half ? 16'(2 * TICK_DIV) : 16'(TICK_DIV);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // internal release sync; async reset path stays in the flops
    nxt_st.rs1 = 1'b1;
    nxt_st.rs2 = st_ff.rs1;
    nxt_st.run = st_ff.rs2;
    nxt_st.sy1 = ardy;
    nxt_st.sy2 = st_ff.sy1;
    nxt_st.tick = 1'b0;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (st_ff.rs2 && !st_ff.run) begin
      nxt_st.half = ~half_clock_strap_n;
      nxt_st.once = once_mode;
    end
    if (st_ff.run && !st_ff.strap_done) begin
      nxt_st.strap_done = 1'b1;
      nxt_st.aden = second_refresh_i;
    end
    // ----------------------------------------
    // tick divider
    // ----------------------------------------
    if (st_ff.run) begin
      if (16'(st_ff.div) + 16'h1 >= div_lim) begin
        nxt_st.div = 8'h0;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.div = st_ff.div + 8'h1;
      end
    end
    // ----------------------------------------
    // apb slave, ready in the first access cycle, no wait state
    // ----------------------------------------
    if (psel && !penable) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = 32'h0;
      unique case (paddr)
        `BCS_OFF_MPAUX: nxt_st.prdata = {14'h0, st_ff.pbase, st_ff.ex, 7'h0};
        `BCS_OFF_LMSEL: nxt_st.prdata = 32'(st_ff.lm_da) << `BCS_DA_BIT;
        `BCS_OFF_UMSEL: nxt_st.prdata = 32'(st_ff.um_da) << `BCS_DA_BIT;
        `BCS_OFF_CMD: nxt_st.prdata = {4'h0, st_ff.req};
        `BCS_OFF_DATA: nxt_st.prdata = {16'h0, st_ff.rdata};
        `BCS_OFF_STAT: nxt_st.prdata = {26'h0, st_ff.strap_done, st_ff.once, st_ff.half,
          st_ff.aden, st_ff.pins.hold_ack, st_ff.pending || st_ff.state != ST_IDLE};
        `BCS_OFF_MODE: nxt_st.prdata = {31'h0, st_ff.psram};
        default: nxt_st.pslverr = 1'b1;
      endcase
      if (pwrite && paddr == `BCS_OFF_CMD && (st_ff.pending || st_ff.state != ST_IDLE))
        nxt_st.pslverr = 1'b1;
    end
    if (psel && penable && st_ff.pready && pwrite && !st_ff.pslverr) begin
      unique case (paddr)
        `BCS_OFF_MPAUX: begin
          nxt_st.pbase = pwdata[17:8];
          nxt_st.ex = pwdata[`BCS_EX_BIT];
        end
        `BCS_OFF_LMSEL: nxt_st.lm_da = pwdata[`BCS_DA_BIT];
        `BCS_OFF_UMSEL: nxt_st.um_da = pwdata[`BCS_DA_BIT];
        `BCS_OFF_CMD: begin
          nxt_st.req = pwdata[27:0];
          nxt_st.pending = 1'b1;
        end
        `BCS_OFF_DATA: nxt_st.wdata = pwdata[15:0];
        `BCS_OFF_MODE: nxt_st.psram = pwdata[0];
        default: nxt_st.wdata = st_ff.wdata;
      endcase
    end
    // ----------------------------------------
    // bus cycle sequencer
    // ----------------------------------------
    if (st_ff.run && st_ff.tick) begin
      unique case (st_ff.state)
        ST_START: begin
          // counted in pclk below; tick plays no part in leaving start for t1
        end
        ST_IDLE: begin
          if (hold_req) begin
            nxt_st.state = ST_HOLD;
          end else if (st_ff.pending) begin
            nxt_st.pending = 1'b0;
            nxt_st.cur = st_ff.req;
            nxt_st.state = ST_T1;
          end
        end
        ST_T1: nxt_st.state = ST_T2;
        ST_T2: nxt_st.state = ST_T3;
        ST_T3: begin
          if (ready) begin
            nxt_st.state = ST_T4;
            if (is_read)
              nxt_st.rdata = ad_i;
          end
        end
        ST_T4: nxt_st.state = ST_IDLE;
        ST_HOLD: if (!hold_req) nxt_st.state = ST_IDLE;
      endcase
    end
    // startup: fetch from the reset address after 6.5 output clocks
    if (st_ff.run && st_ff.state == ST_START) begin
      if (st_ff.cnt + 16'h1 >= 16'(st_ff.half ? 2 * START_CYC : START_CYC)) begin
        nxt_st.state = ST_T1;
        nxt_st.cur = '{region: `BCS_RGN_UPPER, rfsh: 1'b0, lock: 1'b0, dma: 1'b0,
          ctype: `BCS_CT_FETCH, addr: `BCS_RESET_ADDR};
      end else begin
        nxt_st.cnt = st_ff.cnt + 16'h1;
      end
    end
    // ----------------------------------------
    // pin outputs
    // ----------------------------------------
    nxt_st.pins.hold_ack = nxt_st.state == ST_HOLD;
    nxt_st.pins.addr = st_ff.cur.addr;
    nxt_st.pins.ad_oe = 1'b0;
    nxt_st.pins.ad_o = st_ff.cur.addr[15:0];
    nxt_st.pins.rd_n = 1'b1;
    nxt_st.pins.ctype_n = `BCS_CT_PASSIVE;
    nxt_st.pins.dma_flag = 1'b0;
    nxt_st.pins.lock_n = 1'b1;
    nxt_st.pins.sel6_n = 1'b1;
    nxt_st.pins.second_refresh_n = 1'b1;
    nxt_st.pins.rfsh_mid_n = 1'b1;
    unique case (st_ff.state)
      ST_T1: begin
        nxt_st.pins.ad_oe = !addr_off;
        nxt_st.pins.ctype_n = st_ff.cur.ctype;
        nxt_st.pins.lock_n = !st_ff.cur.lock;
        nxt_st.pins.sel6_n = !hit6;
        if (!st_ff.ex)
          nxt_st.pins.a2 = st_ff.cur.addr[2];
        nxt_st.pins.second_refresh_n = !(st_ff.cur.rfsh && !st_ff.psram);
        nxt_st.pins.rfsh_mid_n = !(st_ff.cur.rfsh && st_ff.psram);
      end
      ST_T2, ST_T3, ST_T4: begin
        // reads float the bus first; the strobe follows one pclk later
        nxt_st.pins.ad_oe = is_write;
        nxt_st.pins.ad_o = st_ff.wdata;
        nxt_st.pins.rd_n = !(is_read && !st_ff.pins.ad_oe);
        nxt_st.pins.ctype_n = st_ff.state == ST_T4 ? `BCS_CT_PASSIVE : st_ff.cur.ctype;
        nxt_st.pins.dma_flag = st_ff.cur.dma;
        nxt_st.pins.sel6_n = !hit6 || st_ff.state == ST_T4;
        nxt_st.pins.second_refresh_n = !(st_ff.cur.rfsh && !st_ff.psram) || st_ff.state == ST_T4;
        nxt_st.pins.rfsh_mid_n = !(st_ff.cur.rfsh && st_ff.psram) || st_ff.state == ST_T4;
      end
      default: nxt_st.pins.ad_oe = 1'b0;
    endcase
    if (st_ff.state == ST_T4)
      nxt_st.pins.rd_n = 1'b1;
    // hold floats the status group; a2 keeps its latch
    nxt_st.pins.rd_oe = !nxt_st.pins.hold_ack && !st_ff.once;
    nxt_st.pins.ctype_oe = !nxt_st.pins.hold_ack && !st_ff.once;
    nxt_st.pins.dma_oe = !nxt_st.pins.hold_ack && !st_ff.once;
    nxt_st.pins.a2_oe = !st_ff.ex && !st_ff.once;
    nxt_st.pins.rfsh2_oe = st_ff.strap_done && !nxt_st.pins.hold_ack && !st_ff.once;
    if (nxt_st.pins.hold_ack) begin
      nxt_st.pins.sel6_n = 1'b1;
      nxt_st.pins.ad_oe = 1'b0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // reset clears all but the idle-high pins, state and aden at once; release runs through rs1/rs2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.state <= ST_START;
      st_ff.pins.rd_n <= 1'b1;
      st_ff.pins.ctype_n <= `BCS_CT_PASSIVE;
      st_ff.pins.lock_n <= 1'b1;
      st_ff.pins.sel6_n <= 1'b1;
      st_ff.pins.second_refresh_n <= 1'b1;
      st_ff.pins.rfsh_mid_n <= 1'b1;
      st_ff.aden <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign pins = st_ff.pins;
endmodule // bcs_top
